// ==== iau_pipe_model.sv ====
// Pipeline partner: presents instruction words to the unit.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/10ps
module iau_pipe_model (
    input wire logic aclk,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic has_mem_operand,
    output logic mem_write
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        has_mem_operand = 1'b0;
        mem_write = 1'b0;
    end

    // One word, held across exactly one edge
    task automatic send(input logic [15:0] w, input logic m,
                        input logic wr);
        instr_valid <= 1'b1;
        instr_word <= w;
        has_mem_operand <= m;
        mem_write <= wr;
        @(posedge aclk);
    endtask

    // Released word shows its inverse, never a stale copy
    task automatic idle();
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
    endtask
endmodule // iau_pipe_model

// ==== iau_pkg.sv ====
// Package for the indirect address operand unit.
// Assumes a single 125 MHz clock domain and AXI4-Lite register access.
package iau_pkg;
    // -----------------------------------------------------------------
    // Instruction word fields
    // -----------------------------------------------------------------
    localparam int TYPE_MSB = 15;
    localparam int TYPE_LSB = 8;
    localparam int MODE_BIT = 7;
    localparam int UPD_MSB = 6;
    localparam int UPD_LSB = 4;
    localparam int NXT_BIT = 3;
    localparam int NREG_MSB = 2;
    localparam int NREG_LSB = 0;

    // -----------------------------------------------------------------
    // Register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_STAT0 = 8'h04;
    localparam logic [7:0] ADDR_STAT1 = 8'h08;
    localparam logic [7:0] ADDR_ADDR = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_AR_BASE = 8'h20;
    localparam int PTR_LSB = 0;
    localparam int BUF_LSB = 0;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [15:0] AR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        UPD_NONE = 3'h0, UPD_DEC = 3'h1, UPD_INC = 3'h2, UPD_RSVD = 3'h3,
        UPD_BR_SUB = 3'h4, UPD_IDX_SUB = 3'h5, UPD_IDX_ADD = 3'h6,
        UPD_BR_ADD = 3'h7
    } iau_upd_t;

    // Command register opcodes for the dedicated instructions
    typedef enum logic [1:0] {
        CMD_LOAD = 2'h0, CMD_ADD_IMM = 2'h1, CMD_SUB_IMM = 2'h2,
        CMD_MODIFY = 2'h3
    } iau_cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
    } iau_bus_t;
endpackage : iau_pkg

// ==== iau_unit.sv ====
// Indirect address operand unit: decoder, pointer and aux arithmetic.
// Assumes the pipeline presents one instruction per valid pulse.
`timescale 1ns/10ps
module iau_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic has_mem_operand,
    input wire logic mem_write,
    output logic [15:0] data_rd_addr,
    output logic [15:0] data_wr_addr,
    output logic addr_valid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // -----------------------------------------------------------------
    // Arithmetic helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] bitrev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // Reverse carry via mirrored operands
    function automatic logic [15:0] rc_op(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic sub);
        logic [15:0] s;
        s = sub ? 16'(bitrev(a) - bitrev(b))
                : 16'(bitrev(a) + bitrev(b));
        return bitrev(s);
    endfunction

    function automatic logic [15:0] upd_calc(input logic [2:0] code,
                                             input logic [15:0] ar,
                                             input logic [15:0] idx);
        logic [15:0] r;
        r = ar;
        unique case (iau_pkg::iau_upd_t'(code))
            iau_pkg::UPD_NONE: r = ar;
            iau_pkg::UPD_DEC: r = 16'(ar - 16'h0001);
            iau_pkg::UPD_INC: r = 16'(ar + 16'h0001);
            iau_pkg::UPD_RSVD: r = ar;
            iau_pkg::UPD_BR_SUB: r = rc_op(ar, idx, 1'b1);
            iau_pkg::UPD_IDX_SUB: r = 16'(ar - idx);
            iau_pkg::UPD_IDX_ADD: r = 16'(ar + idx);
            iau_pkg::UPD_BR_ADD: r = rc_op(ar, idx, 1'b0);
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [15:0] ar_r [8];
    logic [15:0] ar_nxt [8];
    logic [2:0] ptr_r, ptr_nxt;
    logic [2:0] buf_r, buf_nxt;
    iau_pkg::iau_bus_t bus_r, bus_nxt;
    logic [15:0] last_instr_r, last_instr_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] wdat_r, wdat_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    logic do_wr;
    logic indirect;
    logic [15:0] cur_ar;

    // Bits 15..8 deliberately unused here
    assign indirect = instr_valid & has_mem_operand
                      & instr_word[iau_pkg::MODE_BIT];
    assign cur_ar = ar_r[ptr_r];
    assign do_wr = aw_got_r & w_got_r & ~bvalid_r;

    // -----------------------------------------------------------------
    // Decode, arithmetic and register file next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [2:0] cmd_reg;
        logic [15:0] cmd_val;
        cmd_reg = wdat_r[18:16];
        cmd_val = wdat_r[15:0];
        ar_nxt = ar_r;
        ptr_nxt = ptr_r;
        buf_nxt = buf_r;
        last_instr_nxt = last_instr_r;
        bus_nxt = '0;
        if (indirect) begin
            last_instr_nxt = instr_word;
            // Address is the value before update
            bus_nxt.addr = cur_ar;
            bus_nxt.wr = mem_write;
            bus_nxt.rd = ~mem_write;
            // Same cycle as decode; any indirect-mode operand instruction qualifies
            ar_nxt[ptr_r] = upd_calc(instr_word[iau_pkg::UPD_MSB:
                iau_pkg::UPD_LSB], cur_ar, ar_r[0]);
            if (instr_word[iau_pkg::NXT_BIT]) begin
                ptr_nxt = instr_word[iau_pkg::NREG_MSB:
                                     iau_pkg::NREG_LSB];
                buf_nxt = ptr_r;
            end else begin
                ptr_nxt = ptr_r;
            end
        end else if (do_wr && aw_addr_r == iau_pkg::ADDR_CMD) begin
            unique case (iau_pkg::iau_cmd_t'(wdat_r[21:20]))
                iau_pkg::CMD_LOAD: ar_nxt[cmd_reg] = cmd_val;
                iau_pkg::CMD_ADD_IMM:
                    ar_nxt[ptr_r] = 16'(cur_ar + cmd_val);
                iau_pkg::CMD_SUB_IMM:
                    ar_nxt[ptr_r] = 16'(cur_ar - cmd_val);
                iau_pkg::CMD_MODIFY:
                    ar_nxt[ptr_r] = upd_calc(wdat_r[6:4], cur_ar,
                                             ar_r[0]);
            endcase
        end else if (do_wr && aw_addr_r == iau_pkg::ADDR_STAT0) begin
            ptr_nxt = wdat_r[iau_pkg::PTR_LSB +: 3];
        end else if (do_wr && aw_addr_r == iau_pkg::ADDR_STAT1) begin
            buf_nxt = wdat_r[iau_pkg::BUF_LSB +: 3];
        end else if (do_wr && aw_addr_r[7:5] == 3'h1
                     && aw_addr_r[1:0] == 2'h0) begin
            ar_nxt[aw_addr_r[4:2]] = wdat_r[15:0];
        end
    end

    // -----------------------------------------------------------------
    // AXI4-Lite slave next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [7:0] ra;
        ra = s_axi_araddr;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_addr_nxt = aw_addr_r;
        wdat_nxt = wdat_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && !aw_got_r) begin
            aw_got_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r) begin
            w_got_nxt = 1'b1;
            wdat_nxt = s_axi_wdata;
        end
        // Indirect decode has priority; a colliding write waits
        if (do_wr && !indirect) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_addr_r == iau_pkg::ADDR_CMD
                || aw_addr_r == iau_pkg::ADDR_STAT0
                || aw_addr_r == iau_pkg::ADDR_STAT1
                || (aw_addr_r[7:5] == 3'h1 && aw_addr_r[1:0] == 2'h0))
                ? 2'h0 : 2'h2;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = 2'h0;
            rdata_nxt = 32'h0000_0000;
            if (ra == iau_pkg::ADDR_INSTR) begin
                rdata_nxt = {16'h0000, last_instr_r};
            end else if (ra == iau_pkg::ADDR_STAT0) begin
                rdata_nxt = {29'h0, ptr_r};
            end else if (ra == iau_pkg::ADDR_STAT1) begin
                rdata_nxt = {29'h0, buf_r};
            end else if (ra == iau_pkg::ADDR_ADDR) begin
                rdata_nxt = {16'h0000, bus_r.addr};
            end else if (ra[7:5] == 3'h1 && ra[1:0] == 2'h0) begin
                rdata_nxt = {16'h0000, ar_r[ra[4:2]]};
            end else if (ra != iau_pkg::ADDR_CMD) begin
                rresp_nxt = 2'h2;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                ar_r[i] <= iau_pkg::AR_RESET;
            end
            ptr_r <= iau_pkg::PTR_RESET;
            buf_r <= iau_pkg::PTR_RESET;
            bus_r <= '0;
            last_instr_r <= 16'h0000;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            wdat_r <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end else begin
            ar_r <= ar_nxt;
            ptr_r <= ptr_nxt;
            buf_r <= buf_nxt;
            bus_r <= bus_nxt;
            last_instr_r <= last_instr_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            wdat_r <= wdat_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign data_rd_addr = bus_r.rd ? bus_r.addr : 16'h0000;
    assign data_wr_addr = bus_r.wr ? bus_r.addr : 16'h0000;
    assign addr_valid = bus_r.rd | bus_r.wr;
    assign s_axi_awready = ~aw_got_r;
    assign s_axi_wready = ~w_got_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ind(logic [2:0] c);
        indirect && instr_word[6:4] == c;
    endsequence

    AST_HOLD: assert property (s_ind(3'h0) |=>
        ar_r[$past(ptr_r)] == $past(cur_ar))
        else $error("code 0 changed register");
    AST_DEC: assert property (s_ind(3'h1) |=>
        ar_r[$past(ptr_r)] == 16'($past(cur_ar) - 16'h0001))
        else $error("decrement wrong");
    AST_INC: assert property (s_ind(3'h2) |=>
        ar_r[$past(ptr_r)] == 16'($past(cur_ar) + 16'h0001))
        else $error("increment wrong");
    AST_RSVD: assert property (s_ind(3'h3) |=>
        ar_r[$past(ptr_r)] == $past(cur_ar))
        else $error("reserved code changed register");
    AST_IDXSUB: assert property (s_ind(3'h5) && ptr_r != 3'h0 |=>
        ar_r[$past(ptr_r)] == 16'($past(cur_ar) - ar_r[0]))
        else $error("index subtract wrong");
    AST_BRADD: assert property (s_ind(3'h7) |=> ar_r[$past(ptr_r)] ==
        bitrev(16'(bitrev($past(cur_ar)) + bitrev($past(ar_r[0])))))
        else $error("reverse carry add wrong");
    AST_ADDR: assert property (indirect |=>
        addr_valid && bus_r.addr == $past(cur_ar))
        else $error("address not pre-update value");
    AST_PTRKEEP: assert property (indirect && !instr_word[3] |=>
        $stable(ptr_r))
        else $error("pointer moved without flag");
    AST_PTRLOAD: assert property (indirect && instr_word[3] |=>
        ptr_r == $past(instr_word[2:0]) && buf_r == $past(ptr_r))
        else $error("pointer load or buffer wrong");
    AST_DIRECT: assert property (instr_valid && !instr_word[7]
        && !do_wr |=> $stable(ptr_r) ##1 !addr_valid[*1])
        else $error("direct mode acted as indirect");
endmodule // iau_unit

// ==== tb_top.sv ====
// Self-checking bench for the indirect address operand unit.
// Assumes one 8 ns clock and the AXI4-Lite map of the package.
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic instr_valid, has_mem_operand, mem_write, addr_valid;
    logic [15:0] instr_word, data_rd_addr, data_wr_addr;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    // Always ready for answers, so no response can stall
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int fails = 0;
    int num_checks = 0;

    always #4 aclk = ~aclk;

    iau_pipe_model pipe (.aclk, .instr_valid, .instr_word,
        .has_mem_operand, .mem_write);

    iau_unit dut (.aclk, .aresetn, .instr_valid, .instr_word,
        .has_mem_operand, .mem_write, .data_rd_addr, .data_wr_addr,
        .addr_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // ----------
    // Bus and check tasks
    // ----------
    task automatic check(input string n, input logic [15:0] got,
                         input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready ||
                    s_axi_wvalid && !s_axi_wready) && ++n < 50);
        do @(posedge aclk); while (!s_axi_bvalid && ++n < 50);
        resp = s_axi_bresp;
        if (n >= 50)
            fails++;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready && ++n < 50);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid && ++n < 50);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 50)
            fails++;
    endtask

    function automatic logic [7:0] ara(input int n);
        return iau_pkg::ADDR_AR_BASE + 8'(4 * n);
    endfunction

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rev[i] = v[15 - i];
    endfunction

    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        axi_rd(ara(0));
        check("ar0_rst", rd[15:0], 16'h0000);
        axi_rd(iau_pkg::ADDR_STAT0);
        check("ptr_rst", rd[15:0], 16'h0000);
        check("av_rst", 16'(addr_valid), 16'h0000);
    endtask

    task automatic t_codes();
        logic [15:0] a, x, e;
        a = 16'h0a38;
        x = 16'h0014;
        for (int c = 0; c < 8; c++) begin
            axi_wr(iau_pkg::ADDR_STAT0, 32'h1);
            axi_wr(ara(0), {16'h0, x});
            axi_wr(ara(1), {16'h0, a});
            case (c)
                1: e = a - 16'h1;
                2: e = a + 16'h1;
                4: e = rev(rev(a) - rev(x));
                5: e = a - x;
                6: e = a + x;
                7: e = rev(rev(a) + rev(x));
                default: e = a;
            endcase
            // Noisy type byte and a next number that must be ignored
            pipe.send({8'ha5, 1'b1, 3'(c), 1'b0, 3'h6}, 1'b1, 1'b0);
            #1;
            check("av", 16'(addr_valid), 16'h0001);
            check("rd_addr", data_rd_addr, a);
            pipe.idle();
            axi_rd(ara(1));
            check("upd", rd[15:0], e);
            axi_rd(iau_pkg::ADDR_STAT0);
            check("ptr_kept", rd[15:0], 16'h0001);
        end
    endtask

    task automatic t_next();
        axi_wr(iau_pkg::ADDR_STAT0, 32'h2);
        axi_wr(ara(2), 32'h0100);
        axi_wr(ara(5), 32'hffff);
        pipe.send({8'h00, 1'b1, 3'h2, 1'b1, 3'h5}, 1'b1, 1'b1);
        #1;
        check("wr_addr", data_wr_addr, 16'h0100);
        pipe.send({8'h00, 1'b1, 3'h2, 1'b0, 3'h0}, 1'b1, 1'b0);
        #1;
        check("b2b_addr", data_rd_addr, 16'hffff);
        pipe.send({8'h00, 1'b1, 3'h1, 1'b0, 3'h0}, 1'b1, 1'b0);
        #1;
        check("wrap_addr", data_rd_addr, 16'h0000);
        pipe.idle();
        axi_rd(iau_pkg::ADDR_STAT0);
        check("ptr_new", rd[15:0], 16'h0005);
        axi_rd(iau_pkg::ADDR_STAT1);
        check("ptr_buf", rd[15:0], 16'h0002);
        axi_rd(ara(2));
        check("side_upd", rd[15:0], 16'h0101);
        axi_rd(ara(5));
        check("wrap", rd[15:0], 16'hffff);
    endtask

    task automatic t_refuse();
        pipe.send({8'h00, 1'b0, 3'h2, 1'b1, 3'h1}, 1'b1, 1'b0);
        #1;
        check("direct", 16'(addr_valid), 16'h0000);
        pipe.idle();
        @(posedge aclk);
        pipe.send({8'h00, 1'b1, 3'h2, 1'b1, 3'h1}, 1'b0, 1'b0);
        #1;
        check("no_opnd", 16'(addr_valid), 16'h0000);
        pipe.idle();
        axi_rd(ara(5));
        check("ar_held", rd[15:0], 16'hffff);
        axi_rd(iau_pkg::ADDR_STAT0);
        check("ptr_held", rd[15:0], 16'h0005);
    endtask

    task automatic t_cmds();
        axi_wr(iau_pkg::ADDR_CMD, 32'h0003_1234);
        axi_rd(ara(3));
        check("load", rd[15:0], 16'h1234);
        axi_wr(iau_pkg::ADDR_STAT0, 32'h3);
        axi_wr(iau_pkg::ADDR_CMD, 32'h0010_0010);
        axi_wr(iau_pkg::ADDR_CMD, 32'h0020_0004);
        axi_rd(ara(3));
        check("imm", rd[15:0], 16'h1240);
        axi_wr(iau_pkg::ADDR_CMD, 32'h0030_0020);
        axi_rd(ara(3));
        check("modify", rd[15:0], 16'h1241);
        axi_wr(8'h1c, 32'h1);
        check("bresp_bad", 16'(resp), 16'h0002);
        axi_rd(8'h1c);
        check("rresp_bad", 16'(resp), 16'h0002);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_codes();
        t_next();
        t_refuse();
        t_cmds();
        repeat (4) @(posedge aclk);
        conclude();
    end

    // Whole run needs a few hundred cycles; this is ample
    initial begin
        #(8 * 20000);
        fails++;
        conclude();
    end
endmodule // tb_top
